// [adcp_sample_ctrl.sv]
// Chosen here: the APB slave port.
`timescale 1ns/1ns
module adcp_sample_ctrl
  import adcp_pkg::*;
(
  input  wire logic                  mclk,       // 250 MHz clock
  input  wire logic                  reset,      // Async reset, high
  input  wire logic                  clkEn,      // Freezes all state when low
  input  wire logic                  psel,       // APB select
  input  wire logic                  penable,    // APB enable
  input  wire logic                  pwrite,     // APB direction
  input  wire logic [7:0]            paddr,      // APB byte address
  input  wire logic [31:0]           pwdata,     // APB write data
  output logic      [31:0]           prdata,     // APB read data
  output logic                       pready,     // APB ready
  output logic                       pslverr,    // APB error
  input  wire logic                  trigger,    // Sample pulse
  input  wire logic [NPIN*RES_W-1:0] convData,   // Results, pin 0 lowest
  output logic                       adcEnable,  // Converter on
  output logic                       calRefSel,  // Sample internal reference
  output logic      [NPIN-1:0]       pinEnable,  // Per-pin sampling enables
  output logic                       txValid,    // Byte or end token valid
  input  wire logic                  txReady,    // Channel-end accepts
  output logic      [23:0]           txDest,     // Channel-end identifier
  output logic      [7:0]            txData,     // Sample byte
  output logic                       txEnd,      // End-of-packet token
  output logic                       irq         // Level interrupt
);

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] fmtSample(input logic [RES_W-1:0] res, input logic [1:0] size);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (size)
      SZ_16:   w = {res, 4'h0, 16'h0000};
      SZ_32:   w = {res, 20'h0_0000};
      default: w = {res[RES_W-1:RES_W-8], 24'h00_0000};
    endcase
    return w;
  endfunction

  function automatic logic [1:0] lastByte(input logic [1:0] size);
    logic [1:0] n;
    n = 2'h0;
    if (size == SZ_16) begin
      n = 2'h1;
    end else if (size == SZ_32) begin
      n = 2'h3;
    end
    return n;
  endfunction

  function automatic logic [7:0] byteOf(input logic [31:0] w, input logic [1:0] idx);
    logic [7:0] b;
    b = w[31 - 8*idx -: 8];
    return b;
  endfunction

  function automatic logic [2:0] firstSet(input logic [NPIN-1:0] m);
    logic [2:0] p;
    p = 3'h0;
    for (int i = NPIN - 1; i >= 0; i--) begin
      if (m[i]) begin
        p = 3'(i);
      end
    end
    return p;
  endfunction

  // ==========================================================================
  // State
  logic [NPIN-1:0][31:0] pinCfg_q,  pinCfg_d;
  logic                  genEn_q,   genEn_d;
  logic                  genCal_q,  genCal_d;
  logic [7:0]            genSpp_q,  genSpp_d;
  logic [1:0]            genSize_q, genSize_d;
  logic                  dropped_q, dropped_d;
  logic [IRQ_W-1:0]      irqStat_q, irqStat_d;
  logic [IRQ_W-1:0]      irqEn_q,   irqEn_d;
  logic                  irq_q,     irq_d;
  logic [31:0]           prdata_q,  prdata_d;
  logic                  pready_q,  pready_d;
  logic                  pslverr_q, pslverr_d;
  logic [2:0]            calCnt_q,  calCnt_d;
  logic [NPIN-1:0][31:0] hold_q,    hold_d;
  logic [NPIN-1:0]       pend_q,    pend_d;
  logic [NPIN-1:0]       open_q,    open_d;
  logic [NPIN-1:0]       endReq_q,  endReq_d;
  logic [NPIN-1:0][7:0]  cnt_q,     cnt_d;
  adcp_tx_t              state_q,   state_d;
  logic [2:0]            txPin_q,   txPin_d;
  logic [1:0]            byteIdx_q, byteIdx_d;
  logic [1:0]            txLast_q,  txLast_d;
  logic                  txValid_q, txValid_d;
  logic [23:0]           txDest_q,  txDest_d;
  logic [7:0]            txData_q,  txData_d;
  logic                  txEnd_q,   txEnd_d;

  logic                  apbSetup, apbDone, addrOk, isPin, ctlAccess, readClr;
  logic [31:0]           readMux;
  logic                  capHit, dropEvt, txDone, endDone;
  logic [NPIN-1:0]       pinEnVec;
  logic [2:0]            pick;

  // ==========================================================================
  // APB slave and registers
  always_comb begin
    apbSetup  = psel && penable && !pready_q;
    apbDone   = psel && penable && pready_q;
    addrOk    = (paddr[1:0] == 2'h0) && (paddr <= OFF_ICLR);
    isPin     = paddr <= OFF_PIN7;
    ctlAccess = apbDone && (paddr <= OFF_GEN);
    readClr   = apbDone && !pwrite && (paddr == OFF_GEN);
    for (int i = 0; i < NPIN; i++) begin
      pinEnVec[i] = pinCfg_q[i][PIN_EN_BIT];
    end
    readMux = 32'h0000_0000;
    if (isPin) begin
      readMux = pinCfg_q[paddr[4:2]];
    end else if (paddr == OFF_GEN) begin
      readMux[GEN_EN_BIT]                     = genEn_q;
      readMux[GEN_CAL_BIT]                    = genCal_q;
      readMux[GEN_SPP_LSB +: 8]               = genSpp_q;
      readMux[GEN_SIZE_LSB +: 2]              = genSize_q;
      readMux[GEN_DROP_BIT]                   = dropped_q;
    end else if (paddr == OFF_STAT) begin
      readMux[IRQ_W-1:0] = irqStat_q;
    end else if (paddr == OFF_IEN) begin
      readMux[IRQ_W-1:0] = irqEn_q;
    end

    pinCfg_d  = pinCfg_q;
    genEn_d   = genEn_q;
    genCal_d  = genCal_q;
    genSpp_d  = genSpp_q;
    genSize_d = genSize_q;
    irqEn_d   = irqEn_q;
    irqStat_d = irqStat_q;
    pready_d  = apbSetup;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    if (apbSetup) begin
      prdata_d  = addrOk ? readMux : 32'h0000_0000;
      pslverr_d = !addrOk;
    end
    if (apbDone && pwrite && addrOk) begin
      if (isPin) begin
        if (!genEn_q) begin
          pinCfg_d[paddr[4:2]] = {pwdata[31:PIN_DEST_LSB], 7'h00, pwdata[PIN_EN_BIT]};
        end
      end else if (paddr == OFF_GEN) begin
        genEn_d   = pwdata[GEN_EN_BIT];
        genCal_d  = pwdata[GEN_CAL_BIT];
        genSpp_d  = pwdata[GEN_SPP_LSB +: 8];
        genSize_d = pwdata[GEN_SIZE_LSB +: 2];
      end else if (paddr == OFF_IEN) begin
        irqEn_d = pwdata[IRQ_W-1:0];
      end else if (paddr == OFF_ICLR) begin
        irqStat_d = irqStat_q & ~pwdata[IRQ_W-1:0];
      end
    end
    // Hardware set wins over software clear
    dropped_d = readClr ? 1'b0 : dropped_q;
    if (dropEvt) begin
      dropped_d          = 1'b1;
      irqStat_d[IRQ_DROP] = 1'b1;
    end
    if (endDone) begin
      irqStat_d[IRQ_PKT] = 1'b1;
    end
    irq_d = |(irqStat_d & irqEn_d);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pinCfg_q  <= {NPIN{PIN_RST}};
      genEn_q   <= 1'b0;
      genCal_q  <= 1'b0;
      genSpp_q  <= GEN_SPP_RST;
      genSize_q <= GEN_SIZE_RST;
      dropped_q <= GEN_DROP_RST;
      irqStat_q <= '0;
      irqEn_q   <= '0;
      irq_q     <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (clkEn) begin
      pinCfg_q  <= pinCfg_d;
      genEn_q   <= genEn_d;
      genCal_q  <= genCal_d;
      genSpp_q  <= genSpp_d;
      genSize_q <= genSize_d;
      dropped_q <= dropped_d;
      irqStat_q <= irqStat_d;
      irqEn_q   <= irqEn_d;
      irq_q     <= irq_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ==========================================================================
  // Calibration count, capture and packet bookkeeping
  always_comb begin
    calCnt_d = calCnt_q;
    if (!genEn_q) begin
      calCnt_d = 3'h0;
    end else if (trigger && (calCnt_q != CAL_PULSES)) begin
      calCnt_d = calCnt_q + 3'h1;
    end
    capHit   = trigger && genEn_q && (calCnt_q == CAL_PULSES);
    dropEvt  = 1'b0;
    hold_d   = hold_q;
    pend_d   = pend_q;
    open_d   = open_q;
    endReq_d = endReq_q;
    cnt_d    = cnt_q;
    if (txDone) begin
      pend_d[txPin_q] = 1'b0;
      open_d[txPin_q] = 1'b1;
      if ((genSpp_q != 8'h00) && (cnt_q[txPin_q] + 8'h01 == genSpp_q)) begin
        endReq_d[txPin_q] = 1'b1;
        cnt_d[txPin_q]    = 8'h00;
      end else begin
        cnt_d[txPin_q] = cnt_q[txPin_q] + 8'h01;
      end
    end
    if (endDone) begin
      endReq_d[txPin_q] = 1'b0;
      open_d[txPin_q]   = 1'b0;
    end
    // An access to a pin or GEN register closes every packet still open
    if (ctlAccess) begin
      endReq_d = endReq_d | open_d;
      open_d   = '0;
      cnt_d    = '0;
    end
    for (int i = 0; i < NPIN; i++) begin
      if (capHit && pinEnVec[i]) begin
        if (pend_d[i]) begin
          dropEvt = 1'b1;
        end else begin
          hold_d[i] = fmtSample(convData[i*RES_W +: RES_W], genSize_q);
          pend_d[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      calCnt_q <= 3'h0;
      hold_q   <= '0;
      pend_q   <= '0;
      open_q   <= '0;
      endReq_q <= '0;
      cnt_q    <= '0;
    end else if (clkEn) begin
      calCnt_q <= calCnt_d;
      hold_q   <= hold_d;
      pend_q   <= pend_d;
      open_q   <= open_d;
      endReq_q <= endReq_d;
      cnt_q    <= cnt_d;
    end
  end

  // ==========================================================================
  // Byte transmitter; the lowest-numbered pin with data or an end token goes first, its end token ahead of its data
  always_comb begin
    pick      = firstSet(pend_q | endReq_q);
    state_d   = state_q;
    txPin_d   = txPin_q;
    byteIdx_d = byteIdx_q;
    txLast_d  = txLast_q;
    txValid_d = txValid_q;
    txDest_d  = txDest_q;
    txData_d  = txData_q;
    txEnd_d   = txEnd_q;
    txDone    = 1'b0;
    endDone   = 1'b0;
    unique case (state_q)
      TX_IDLE: begin
        if (|(pend_q | endReq_q)) begin
          txPin_d   = pick;
          txValid_d = 1'b1;
          txDest_d  = pinCfg_q[pick][31:PIN_DEST_LSB];
          if (endReq_q[pick]) begin
            txEnd_d = 1'b1;
            state_d = TX_END;
          end else begin
            byteIdx_d = 2'h0;
            txLast_d  = lastByte(genSize_q);
            txData_d  = byteOf(hold_q[pick], 2'h0);
            state_d   = TX_DATA;
          end
        end
      end
      TX_DATA: begin
        if (txReady) begin
          if (byteIdx_q == txLast_q) begin
            txDone    = 1'b1;
            txValid_d = 1'b0;
            state_d   = TX_IDLE;
          end else begin
            byteIdx_d = byteIdx_q + 2'h1;
            txData_d  = byteOf(hold_q[txPin_q], byteIdx_q + 2'h1);
          end
        end
      end
      TX_END: begin
        if (txReady) begin
          endDone   = 1'b1;
          txValid_d = 1'b0;
          txEnd_d   = 1'b0;
          state_d   = TX_IDLE;
        end
      end
      default: state_d = TX_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q   <= TX_IDLE;
      txPin_q   <= 3'h0;
      byteIdx_q <= 2'h0;
      txLast_q  <= 2'h0;
      txValid_q <= 1'b0;
      txDest_q  <= 24'h00_0000;
      txData_q  <= 8'h00;
      txEnd_q   <= 1'b0;
    end else if (clkEn) begin
      state_q   <= state_d;
      txPin_q   <= txPin_d;
      byteIdx_q <= byteIdx_d;
      txLast_q  <= txLast_d;
      txValid_q <= txValid_d;
      txDest_q  <= txDest_d;
      txData_q  <= txData_d;
      txEnd_q   <= txEnd_d;
    end
  end

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign adcEnable = genEn_q;
  assign calRefSel = genCal_q;
  assign pinEnable = pinEnVec;
  assign txValid   = txValid_q;
  assign txDest    = txDest_q;
  assign txData    = txData_q;
  assign txEnd     = txEnd_q;
  assign irq       = irq_q;

  // ==========================================================================
  // Checks
  logic [RES_W-1:0] conv0;
  logic [7:0]       holdTop;
  logic             endReqSel;
  assign conv0     = convData[RES_W-1:0];
  assign holdTop   = hold_q[txPin_q][31:24];
  assign endReqSel = endReq_q[txPin_q];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_pinWrite;
    clkEn && apbDone && pwrite && isPin && genEn_q;
  endsequence
  sequence s_lastOfPacket;
    clkEn && txDone && (genSpp_q != 8'h00) && (cnt_q[txPin_q] + 8'h01 == genSpp_q);
  endsequence
  sequence s_cap0;
    clkEn && capHit && pinEnVec[0] && !pend_q[0];
  endsequence

  property p_pinLocked;
    s_pinWrite |=> $stable(pinCfg_q);
  endproperty
  a_pinLocked: assert property (p_pinLocked) else $error("pin register changed while enabled");

  property p_dropClear;
    clkEn && readClr && !dropEvt |=> !dropped_q;
  endproperty
  a_dropClear: assert property (p_dropClear) else $error("dropped flag not cleared by read");

  property p_dropSet;
    clkEn && capHit && |(pinEnVec & pend_q & ~{NPIN{txDone}}) |=> dropped_q && irqStat_q[IRQ_DROP];
  endproperty
  a_dropSet: assert property (p_dropSet) else $error("lost sample not flagged");

  property p_calQuiet;
    trigger && (calCnt_q != CAL_PULSES) |-> !capHit;
  endproperty
  a_calQuiet: assert property (p_calQuiet) else $error("sample taken during calibration");

  property p_pinGate;
    clkEn |=> ((pend_q & ~$past(pend_q)) & ~$past(pinEnVec)) == '0;
  endproperty
  a_pinGate: assert property (p_pinGate) else $error("disabled pin produced a sample");

  property p_fmt8;
    s_cap0 and (genSize_q == SZ_8) |=> hold_q[0] == {$past(conv0[RES_W-1:4]), 24'h00_0000};
  endproperty
  a_fmt8: assert property (p_fmt8) else $error("8-bit sample wrongly formatted");

  property p_fmt16;
    s_cap0 and (genSize_q == SZ_16) |=> hold_q[0] == {$past(conv0), 20'h0_0000};
  endproperty
  a_fmt16: assert property (p_fmt16) else $error("16-bit sample wrongly formatted");

  property p_fmt32;
    s_cap0 and (genSize_q == SZ_32) |=> hold_q[0][31:20] == $past(conv0) && hold_q[0][19:0] == 20'h0_0000;
  endproperty
  a_fmt32: assert property (p_fmt32) else $error("32-bit sample wrongly formatted");

  property p_msbFirst;
    $rose(txValid_q) && !txEnd_q |-> txData_q == holdTop && byteIdx_q == 2'h0;
  endproperty
  a_msbFirst: assert property (p_msbFirst) else $error("first byte is not the top byte");

  property p_pktEnd;
    s_lastOfPacket |=> endReqSel;
  endproperty
  a_pktEnd: assert property (p_pktEnd) else $error("packet not terminated at count");

  property p_accessClose;
    // An end token finishing in the same cycle legitimately leaves its pin closed
    clkEn && ctlAccess && !endDone |=> (endReq_q & $past(open_q)) == $past(open_q) && open_q == '0;
  endproperty
  a_accessClose: assert property (p_accessClose) else $error("open packet not closed by access");

endmodule

// [adcp_pkg.sv]
package adcp_pkg;

  // ==========================================================================
  // Sizes
  localparam int          NPIN        = 8;
  localparam int          RES_W       = 12;
  localparam int          IRQ_W       = 2;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0]  OFF_PIN0    = 8'h00;
  localparam logic [7:0]  OFF_PIN7    = 8'h1C;
  localparam logic [7:0]  OFF_GEN     = 8'h20;
  localparam logic [7:0]  OFF_STAT    = 8'h24;
  localparam logic [7:0]  OFF_IEN     = 8'h28;
  localparam logic [7:0]  OFF_ICLR    = 8'h2C;

  // ==========================================================================
  // Field positions
  localparam int          PIN_EN_BIT   = 0;
  localparam int          PIN_DEST_LSB = 8;
  localparam int          GEN_EN_BIT   = 0;
  localparam int          GEN_CAL_BIT  = 1;
  localparam int          GEN_SPP_LSB  = 8;
  localparam int          GEN_SIZE_LSB = 16;
  localparam int          GEN_DROP_BIT = 24;
  localparam int          IRQ_DROP     = 0;
  localparam int          IRQ_PKT      = 1;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] PIN_RST      = 32'h0000_0000;
  localparam logic [1:0]  GEN_SIZE_RST = 2'h1;
  localparam logic [7:0]  GEN_SPP_RST  = 8'h01;
  localparam logic        GEN_DROP_RST = 1'b1;

  // ==========================================================================
  // Sample size codes and calibration
  localparam logic [1:0]  SZ_8        = 2'h0;
  localparam logic [1:0]  SZ_16       = 2'h1;
  localparam logic [1:0]  SZ_32       = 2'h3;
  localparam logic [2:0]  CAL_PULSES  = 3'h6;

  typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_END} adcp_tx_t;

endpackage

// [adcp_chan_model.sv]
`timescale 1ns/1ns
module adcp_chan_model (
  input  wire logic        mclk,     // Clock
  input  wire logic        reset,    // Async reset, high
  input  wire logic [1:0]  mode,     // 0 prompt, 1 slow, 2 stall
  input  wire logic        txValid,  // Offer from block
  input  wire logic [23:0] txDest,   // Destination
  input  wire logic [7:0]  txData,   // Sample byte
  input  wire logic        txEnd,    // End token
  output logic             txReady   // Accept
);
  logic [32:0] got[$];
  logic        tick_q;

  // ==========================================================================
  // Acceptance log
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= !tick_q;
      if (txValid && txReady) begin
        got.push_back({txEnd, txDest, txData});
      end
    end
  end

  // Slow mode accepts only every other cycle, to back up the block
  assign txReady = (mode == 2'h0) || ((mode == 2'h1) && tick_q);
endmodule

// [tb_adc_sample_packet_control.sv]
`timescale 1ns/1ns
module tb_adc_sample_packet_control
  import adcp_pkg::*;
();
  typedef struct packed {
    logic [1:0]  size;
    logic [7:0]  spp;
    logic        cal;
    logic [2:0]  pin;
    logic [11:0] res;
    logic [23:0] dest;
    logic [1:0]  mode;
  } adcp_row_t;

  logic                  mclk = 1'b0;
  logic                  reset = 1'b1;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0;
  logic                  trigger = 1'b0;
  logic [NPIN*RES_W-1:0] convData = '0;
  logic [1:0]            mode = 2'h0;
  logic [31:0]           prdata, rd, w;
  logic                  pready, pslverr, er, adcEnable, calRefSel, irq;
  logic [NPIN-1:0]       pinEnable;
  logic                  txValid, txReady, txEnd;
  logic [23:0]           txDest;
  logic [7:0]            txData;
  int                    err_total = 0;
  int                    check_count = 0;
  int                    cycles = 0;
  int                    n, k;
  logic [11:0]           v;
  adcp_row_t             r;
  adcp_row_t             rows[4] = '{
    '{SZ_8,  8'h01, 1'b0, 3'h0, 12'hABC, 24'h123456, 2'h0},
    '{SZ_16, 8'h02, 1'b1, 3'h3, 12'h5A1, 24'hFEDCBA, 2'h1},
    '{SZ_32, 8'h01, 1'b0, 3'h7, 12'hF0F, 24'h00C0DE, 2'h0},
    '{2'h2,  8'h01, 1'b0, 3'h5, 12'h3C5, 24'h0A0B0C, 2'h1}};

  adcp_sample_ctrl u_dut (
    .mclk(mclk), .reset(reset), .clkEn(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trigger(trigger), .convData(convData),
    .adcEnable(adcEnable), .calRefSel(calRefSel), .pinEnable(pinEnable),
    .txValid(txValid), .txReady(txReady), .txDest(txDest), .txData(txData),
    .txEnd(txEnd), .irq(irq));

  adcp_chan_model u_chan (
    .mclk(mclk), .reset(reset), .mode(mode), .txValid(txValid),
    .txDest(txDest), .txData(txData), .txEnd(txEnd), .txReady(txReady));

  initial begin
    forever #2 mclk = !mclk;
  end

  // ==========================================================================
  // Tasks
  task automatic results();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [32:0] exp, input logic [32:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Master waits for pready; the timeout is the only bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Look mid-cycle so the answer is settled, then let its edge pass
    @(negedge mclk);
    while (pready !== 1'b1) @(negedge mclk);
    rd = prdata;
    er = pslverr;
    @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [32:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, {er, rd});
  endtask

  task automatic trig(input int cnt, input int gap);
    repeat (cnt) begin
      @(posedge mclk);
      trigger <= 1'b1;
      @(posedge mclk);
      trigger <= 1'b0;
      repeat (gap) @(posedge mclk);
    end
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    chk("txValid rst", 33'h0, {32'h0, txValid});
    rdc("gen rst", OFF_GEN, {1'b0, 32'h0101_0100});
    rdc("pin7 rst", OFF_PIN7, 33'h0);
    rdc("gen cleared", OFF_GEN, {1'b0, 32'h0001_0100});
    rdc("unmapped", 8'h30, {1'b1, 32'h0});
    foreach (rows[i]) begin
      r = rows[i];
      mode <= r.mode;
      apb(1'b1, OFF_GEN, 32'h0);
      for (int p = 0; p < NPIN; p++) begin
        apb(1'b1, OFF_PIN0 + 8'(4 * p), (p == r.pin) ? {r.dest, 8'h01} : 32'h0);
        convData[p*RES_W +: RES_W] <= r.res ^ 12'(p);
      end
      rdc("pin reg", OFF_PIN0 + 8'(4 * r.pin), {1'b0, r.dest, 8'h01});
      apb(1'b1, OFF_GEN, {14'h0, r.size, r.spp, 6'h0, r.cal, 1'b1});
      repeat (2) @(posedge mclk);
      chk("ctl", {23'h0, 1'b1, r.cal, 8'(1 << r.pin)}, {23'h0, adcEnable, calRefSel, pinEnable});
      u_chan.got.delete();
      trig(6, 10);
      chk("cal quiet", 33'h0, 33'(u_chan.got.size()));
      trig(r.spp, 20);
      v = r.res ^ 12'(r.pin);
      case (r.size)
        SZ_16:   begin n = 2; w = {v, 4'h0, 16'h0}; end
        SZ_32:   begin n = 4; w = {v, 20'h0}; end
        default: begin n = 1; w = {v[11:4], 24'h0}; end
      endcase
      chk("count", 33'(r.spp * n + 1), 33'(u_chan.got.size()));
      k = 0;
      for (int s = 0; s < r.spp; s++) begin
        for (int b = 0; b < n; b++) begin
          chk("byte", {1'b0, r.dest, w[31-8*b -: 8]}, u_chan.got[k]);
          k++;
        end
      end
      chk("end", {8'h0, 1'b1, r.dest}, {8'h0, u_chan.got[k][32:8]});
    end
    // Converter still on: pin register must not change
    apb(1'b1, OFF_PIN0, 32'hFFFF_FF01);
    rdc("pin locked", OFF_PIN0, 33'h0);
    apb(1'b1, OFF_GEN, 32'h0);
    // Last row's pin is still enabled and would add its own bytes
    apb(1'b1, OFF_PIN0 + 8'(4 * r.pin), 32'h0);
    apb(1'b1, OFF_PIN0, {24'h00BEEF, 8'h01});
    mode <= 2'h0;
    convData <= {{(NPIN-1)*RES_W{1'b0}}, 12'h9A7};
    apb(1'b1, OFF_GEN, 32'h0000_0001);
    u_chan.got.delete();
    trig(6, 10);
    trig(2, 20);
    chk("open count", 33'h2, 33'(u_chan.got.size()));
    chk("open byte", {1'b0, 24'h00BEEF, 8'h9A}, u_chan.got[1]);
    apb(1'b0, OFF_GEN, 32'h0);
    repeat (10) @(posedge mclk);
    chk("closed count", 33'h3, 33'(u_chan.got.size()));
    chk("closed tok", {8'h0, 1'b1, 24'h00BEEF}, {8'h0, u_chan.got[2][32:8]});
    // Stalled far side: second sample must be lost
    mode <= 2'h2;
    trig(2, 20);
    apb(1'b0, OFF_STAT, 32'h0);
    chk("stat drop", 33'h1, {32'h0, rd[0]});
    apb(1'b0, OFF_GEN, 32'h0);
    chk("gen drop", 33'h1, {32'h0, rd[GEN_DROP_BIT]});
    apb(1'b0, OFF_GEN, 32'h0);
    chk("gen drop clr", 33'h0, {32'h0, rd[GEN_DROP_BIT]});
    chk("irq masked", 33'h0, {32'h0, irq});
    apb(1'b1, OFF_IEN, 32'h1);
    repeat (2) @(posedge mclk);
    chk("irq on", 33'h1, {32'h0, irq});
    apb(1'b1, OFF_ICLR, 32'h1);
    repeat (2) @(posedge mclk);
    chk("irq clr", 33'h0, {32'h0, irq});
    mode <= 2'h0;
    repeat (20) @(posedge mclk);
    results();
  end
endmodule
